// ===== core/dsir_pkg.sv
// Purpose: constants and state types shared by the dma sync and irq routing block
// Assumes: 16-bit data-space register port; six channels
// Notes: subbank words live in dsir_subbank_mem
package dsir_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 6;
	localparam int DATA_W = 16;
	localparam int SUB_AW = 6;
	localparam int SUB_DEPTH = 64;

	// ----------------------------------------------------------------
	// directly addressed registers
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_PRIORITY_ENABLE_CTRL = 16'h0054;
	localparam logic [15:0] ADDR_SUBBANK_POINTER = 16'h0055;
	localparam logic [15:0] ADDR_SUBBANK_DATA_AUTOINC = 16'h0056;
	localparam logic [15:0] ADDR_SUBBANK_DATA_PLAIN = 16'h0057;
	localparam logic [15:0] PREC_RESET = 16'h0000;
	localparam logic [15:0] POINTER_RESET = 16'h0000;
	localparam logic [15:0] POINTER_STEP = 16'h0001;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LINE_SEL_LSB = 6;
	localparam int SYNC_LSB = 12;
	localparam int MCR_IRQ_ENABLE_BIT = 14;
	localparam int MCR_IRQ_TIMING_BIT = 13;
	localparam int MCR_ABU_BIT = 12;

	// ----------------------------------------------------------------
	// subbank layout: five words per channel
	// ----------------------------------------------------------------
	localparam logic [5:0] SUB_STRIDE = 6'h05;
	localparam logic [5:0] SUB_SFC_OFS = 6'h03;
	localparam logic [5:0] SUB_MCR_OFS = 6'h04;

	// ----------------------------------------------------------------
	// sync select codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SYNC_NONE = 4'h0;
	localparam logic [3:0] SYNC_SER0_RX = 4'h1;
	localparam logic [3:0] SYNC_SER0_TX = 4'h2;
	localparam logic [3:0] SYNC_SER1_RX = 4'h5;
	localparam logic [3:0] SYNC_SER1_TX = 4'h6;
	localparam logic [3:0] SYNC_TIMER0 = 4'hd;
	localparam logic [3:0] SYNC_EXT3 = 4'he;
	localparam logic [3:0] SYNC_TIMER1 = 4'hf;

	// ----------------------------------------------------------------
	// interrupt line select values
	// ----------------------------------------------------------------
	localparam logic [1:0] LINES_RESET_MAP = 2'h0;
	localparam logic [1:0] LINES_DMA_2_3 = 2'h1;
	localparam logic [1:0] LINES_DMA_0_3 = 2'h2;

	typedef struct packed {
		logic [SUB_DEPTH-1:0][DATA_W-1:0] word;
		logic [DATA_W-1:0] rdata;
	} dsir_mem_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] prec;
		logic [DATA_W-1:0] ptr;
		logic [NUM_CH-1:0][3:0] sync_sel;
		logic [NUM_CH-1:0] irq_en;
		logic [NUM_CH-1:0] irq_timing;
		logic [NUM_CH-1:0] auto_buffering_mode;
		logic ext3_s1;
		logic ext3_s2;
		logic ext3_d;
		logic rd_p1;
		logic rd_mem_p1;
		logic [DATA_W-1:0] rd_mmr_p1;
		logic rd_valid;
		logic [DATA_W-1:0] rdata;
		logic [NUM_CH-1:0] sync_evt;
		logic [NUM_CH-1:0] unsync;
		logic line6;
		logic line7;
		logic line10;
		logic line11;
		logic ch4_irq;
		logic ch5_irq;
	} dsir_state_t;
endpackage : dsir_pkg

// ===== core/dsir_subbank_mem.sv
// Purpose: subbank register words behind the two data ports
// Assumes: one access per cycle; write wins if both strobes are high
// Notes: read data comes out of a register one edge after the request
module dsir_subbank_mem (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// access
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [dsir_pkg::SUB_AW-1:0] addr,
	input wire logic [dsir_pkg::DATA_W-1:0] wdata,
	output logic [dsir_pkg::DATA_W-1:0] rdata
);
	import dsir_pkg::*;

	dsir_mem_state_t st;
	dsir_mem_state_t next_st;

	// write stores, read registers the addressed word
	always_comb begin
		next_st = st;
		if (wr_en) begin
			next_st.word[addr] = wdata;
		end else if (rd_en) begin
			next_st.rdata = st.word[addr];
		end
	end

	// whole array clears at reset so reads never return unknowns
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
endmodule : dsir_subbank_mem

// ===== core/dsir_top.sv
// Purpose: dma sync event selection, channel interrupt generation, cpu line routing
// Assumes: peripheral events and engine status are pulses on ref_clk; ext irq 3 is a pin
// Notes: reads answer two edges after the request; writes take effect at the next edge
//
// Behaviour
// - interrupt enable bit 0 blocks every interrupt of that channel.
// - auto-buffering: timing 0 interrupts at full, timing 1 at half and full.
// - multi-frame: timing 0 interrupts at block end, timing 1 also each frame end.
// - each channel paced by the event in its 4-bit select; zero means unsynchronised.
// - codes 0001b/0010b serial 0 rx/tx, 0101b/0110b serial 1 rx/tx.
// - codes 1101b timer 0, 1110b external interrupt 3, 1111b timer 1.
// - every channel can interrupt; channels 0 to 3 via shared cpu lines.
// - ch1 shares line 7 with timer 1; ch2/ch3 lines 10/11; ch0 line 6.
// - reset line select 00b keeps timer 1 and serial 1 irqs on the lines.
// - line select 01b puts channels 2 and 3 on lines 10 and 11.
// - line select 10b puts channels 0 to 3 on lines 6, 7, 10, 11.
// - control register at 54h, subbank pointer at 55h.
// - auto-advance data port at 56h, plain data port at 57h.
// - access through the auto-advance port increments the pointer afterwards.
// - all other dma registers are reached only through pointer and data ports.
module dsir_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// cpu data-space register port
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [dsir_pkg::DATA_W-1:0] cpu_wdata,
	output logic [dsir_pkg::DATA_W-1:0] cpu_rdata,
	output logic cpu_rd_valid,
	// synchronising sources
	input wire logic serial0_rx_evt,
	input wire logic serial0_tx_evt,
	input wire logic serial1_rx_evt,
	input wire logic serial1_tx_evt,
	input wire logic timer0_irq,
	input wire logic ext_irq3_pin,
	// shared cpu interrupt sources
	input wire logic timer1_irq,
	input wire logic serial1_rx_irq,
	input wire logic serial1_tx_irq,
	// transfer engine status, per channel
	input wire logic [dsir_pkg::NUM_CH-1:0] buf_half_evt,
	input wire logic [dsir_pkg::NUM_CH-1:0] buf_full_evt,
	input wire logic [dsir_pkg::NUM_CH-1:0] frame_end_evt,
	input wire logic [dsir_pkg::NUM_CH-1:0] block_end_evt,
	// pacing to the transfer engine
	output logic [dsir_pkg::NUM_CH-1:0] chan_sync_evt,
	output logic [dsir_pkg::NUM_CH-1:0] chan_unsync,
	// cpu interrupt lines
	output logic cpu_irq_line6,
	output logic cpu_irq_line7,
	output logic cpu_irq_line10,
	output logic cpu_irq_line11,
	output logic dma_ch4_irq,
	output logic dma_ch5_irq
);
	import dsir_pkg::*;

	dsir_state_t st;
	dsir_state_t next_st;

	logic hit_prec;
	logic hit_ptr;
	logic hit_inc;
	logic hit_plain;
	logic mem_wr;
	logic mem_rd;
	logic ext3_rise;
	logic [1:0] line_sel;
	logic [NUM_CH-1:0] chan_irq;
	logic [NUM_CH-1:0] evt_now;
	logic [DATA_W-1:0] mem_rdata;
	logic [SUB_AW-1:0] sub_idx;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// only four locations exist; everything else reads zero and ignores writes
	always_comb begin
		hit_prec = 1'b0;
		hit_ptr = 1'b0;
		hit_inc = 1'b0;
		hit_plain = 1'b0;
		if (cpu_addr == ADDR_PRIORITY_ENABLE_CTRL) begin
			hit_prec = 1'b1;
		end else if (cpu_addr == ADDR_SUBBANK_POINTER) begin
			hit_ptr = 1'b1;
		end else if (cpu_addr == ADDR_SUBBANK_DATA_AUTOINC) begin
			hit_inc = 1'b1;
		end else if (cpu_addr == ADDR_SUBBANK_DATA_PLAIN) begin
			hit_plain = 1'b1;
		end
	end

	// channel words sit only behind the data ports
	assign sub_idx = st.ptr[SUB_AW-1:0];
	assign mem_wr = cpu_wr && (hit_inc || hit_plain);
	assign mem_rd = cpu_rd && !cpu_wr && (hit_inc || hit_plain);

	dsir_subbank_mem u_mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(mem_wr),
		.rd_en(mem_rd),
		.addr(sub_idx),
		.wdata(cpu_wdata),
		.rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// event selection and channel interrupts
	// ----------------------------------------------------------------
	// edge taken from the second sync stage so a slow pin counts once
	assign ext3_rise = st.ext3_s2 && !st.ext3_d;
	assign line_sel = st.prec[LINE_SEL_LSB +: 2];

	always_comb begin
		for (int ch = 0; ch < NUM_CH; ch++) begin
			case (st.sync_sel[ch])
				SYNC_SER0_RX: evt_now[ch] = serial0_rx_evt;
				SYNC_SER0_TX: evt_now[ch] = serial0_tx_evt;
				SYNC_SER1_RX: evt_now[ch] = serial1_rx_evt;
				SYNC_SER1_TX: evt_now[ch] = serial1_tx_evt;
				SYNC_TIMER0: evt_now[ch] = timer0_irq;
				SYNC_EXT3: evt_now[ch] = ext3_rise;
				SYNC_TIMER1: evt_now[ch] = timer1_irq;
				default: evt_now[ch] = 1'b0;
			endcase
			if (!st.irq_en[ch]) begin
				chan_irq[ch] = 1'b0;
			end else if (st.auto_buffering_mode[ch]) begin
				chan_irq[ch] = buf_full_evt[ch] || (st.irq_timing[ch] && buf_half_evt[ch]);
			end else begin
				chan_irq[ch] = block_end_evt[ch] || (st.irq_timing[ch] && frame_end_evt[ch]);
			end
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// external interrupt 3 crosses in through two flops
		next_st.ext3_s1 = ext_irq3_pin;
		next_st.ext3_s2 = st.ext3_s1;
		next_st.ext3_d = st.ext3_s2;

		// direct registers
		if (cpu_wr && hit_prec) begin
			next_st.prec = cpu_wdata;
		end
		if (cpu_wr && hit_ptr) begin
			next_st.ptr = cpu_wdata;
		end else if ((cpu_wr || cpu_rd) && hit_inc) begin
			next_st.ptr = st.ptr + POINTER_STEP;
		end

		// shadow the channel fields this block acts on as they are written
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (mem_wr && sub_idx == 6'(ch) * SUB_STRIDE + SUB_SFC_OFS) begin
				next_st.sync_sel[ch] = cpu_wdata[SYNC_LSB +: 4];
			end
			if (mem_wr && sub_idx == 6'(ch) * SUB_STRIDE + SUB_MCR_OFS) begin
				next_st.irq_en[ch] = cpu_wdata[MCR_IRQ_ENABLE_BIT];
				next_st.irq_timing[ch] = cpu_wdata[MCR_IRQ_TIMING_BIT];
				next_st.auto_buffering_mode[ch] = cpu_wdata[MCR_ABU_BIT];
			end
			// reserved codes behave like no synchronisation
			next_st.unsync[ch] = !(st.sync_sel[ch] inside {SYNC_SER0_RX, SYNC_SER0_TX,
				SYNC_SER1_RX, SYNC_SER1_TX, SYNC_TIMER0, SYNC_EXT3, SYNC_TIMER1});
		end
		next_st.sync_evt = evt_now;

		// read pipeline: capture at request, mux with memory word one edge later
		next_st.rd_p1 = cpu_rd && !cpu_wr;
		next_st.rd_mem_p1 = mem_rd;
		next_st.rd_mmr_p1 = '0;
		if (hit_prec) begin
			next_st.rd_mmr_p1 = st.prec;
		end else if (hit_ptr) begin
			next_st.rd_mmr_p1 = st.ptr;
		end
		next_st.rd_valid = st.rd_p1;
		next_st.rdata = '0;
		if (st.rd_p1) begin
			next_st.rdata = st.rd_mem_p1 ? mem_rdata : st.rd_mmr_p1;
		end

		// line routing; 00b and the reserved 11b keep the reset mapping
		next_st.line6 = 1'b0;
		next_st.line7 = timer1_irq;
		next_st.line10 = serial1_rx_irq;
		next_st.line11 = serial1_tx_irq;
		if (line_sel == LINES_DMA_2_3) begin
			next_st.line10 = chan_irq[2];
			next_st.line11 = chan_irq[3];
		end else if (line_sel == LINES_DMA_0_3) begin
			next_st.line6 = chan_irq[0];
			next_st.line7 = chan_irq[1];
			next_st.line10 = chan_irq[2];
			next_st.line11 = chan_irq[3];
		end
		// channels 4 and 5 have lines of their own
		next_st.ch4_irq = chan_irq[4];
		next_st.ch5_irq = chan_irq[5];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset sets line select 00b so no dma interrupt of channels 0 to 3 reaches the cpu
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.prec <= PREC_RESET;
			st.ptr <= POINTER_RESET;
			st.unsync <= '1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	assign cpu_rdata = st.rdata;
	assign cpu_rd_valid = st.rd_valid;
	assign chan_sync_evt = st.sync_evt;
	assign chan_unsync = st.unsync;
	assign cpu_irq_line6 = st.line6;
	assign cpu_irq_line7 = st.line7;
	assign cpu_irq_line10 = st.line10;
	assign cpu_irq_line11 = st.line11;
	assign dma_ch4_irq = st.ch4_irq;
	assign dma_ch5_irq = st.ch5_irq;
endmodule : dsir_top

// ===== tb/dsir_src_model.sv
// Purpose: far-side sources: serial ports, timers, ext pin, shared irqs
// Assumes: one source fired per request
// Notes: a request seen at one falling edge pulses its source for the next cycle
module dsir_src_model (
	// clock
	input wire logic ref_clk,
	// request from the bench
	input wire logic fire,
	input wire logic [3:0] code,
	// sources, one bit each
	output logic [8:0] src
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle sources sit low, as the real pulse outputs do between events
	initial src = 9'h000;
	always @(negedge ref_clk) begin
		src <= 9'h000;
		if (fire) begin
			src[code] <= 1'b1;
		end
	end
endmodule : dsir_src_model

// ===== tb/dsir_top_asserts.sv
// Purpose: port-level checks of dsir_top
// Assumes: line select mirrored from writes at the control address
// Notes: bound to every dsir_top
module dsir_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [15:0] cpu_wdata,
	input wire logic [15:0] cpu_rdata,
	input wire logic cpu_rd_valid,
	// sources and lines
	input wire logic timer1_irq,
	input wire logic serial1_rx_irq,
	input wire logic [5:0] buf_half_evt,
	input wire logic [5:0] buf_full_evt,
	input wire logic [5:0] frame_end_evt,
	input wire logic [5:0] block_end_evt,
	input wire logic [5:0] chan_sync_evt,
	input wire logic [5:0] chan_unsync,
	input wire logic cpu_irq_line6,
	input wire logic cpu_irq_line7,
	input wire logic cpu_irq_line10,
	input wire logic dma_ch4_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] sel;
	logic [5:0] cause;
	// ----
	// helpers
	// ----
	assign cause = buf_half_evt | buf_full_evt | frame_end_evt | block_end_evt;
	// mirror of the line select; routing lags it by one edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel <= 2'h0;
		end else if (cpu_wr && cpu_addr == 16'h0054) begin
			sel <= cpu_wdata[7:6];
		end
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	line7_timer_a: assert property ($past(sel) != 2'h2 |-> cpu_irq_line7 == $past(timer1_irq))
		else $error("line 7 lost timer 1");
	line10_serial_a: assert property ($past(sel) inside {2'h0, 2'h3}
		|-> cpu_irq_line10 == $past(serial1_rx_irq))
		else $error("line 10 lost serial 1 rx");
	line6_reserved_a: assert property ($past(sel) != 2'h2 |-> !cpu_irq_line6)
		else $error("line 6 active while reserved");
	rd_answer_a: assert property (cpu_rd && !cpu_wr |-> ##2 cpu_rd_valid)
		else $error("read not answered");
	rd_spurious_a: assert property (cpu_rd_valid |-> $past(cpu_rd, 2) && !$past(cpu_wr, 2))
		else $error("answer without read");
	rdata_idle_a: assert property (!cpu_rd_valid |-> cpu_rdata == 16'h0000)
		else $error("read data outside answer");
	sync_excl_a: assert property ((chan_sync_evt & chan_unsync) == 6'h00)
		else $error("event on unsynchronised channel");
	ch4_cause_a: assert property (dma_ch4_irq |-> $past(cause[4]))
		else $error("channel 4 irq without cause");
	cover property ($past(sel) == 2'h2 && cpu_irq_line6);
	cover property (dma_ch4_irq);
	cover property (chan_sync_evt[0]);
endmodule : dsir_checker

bind dsir_top dsir_checker dsir_checker_inst (.ref_clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd,
	.cpu_wdata, .cpu_rdata, .cpu_rd_valid, .timer1_irq, .serial1_rx_irq, .buf_half_evt,
	.buf_full_evt, .frame_end_evt, .block_end_evt, .chan_sync_evt, .chan_unsync,
	.cpu_irq_line6, .cpu_irq_line7, .cpu_irq_line10, .dma_ch4_irq);

// ===== tb/tb.sv
// Purpose: register, pacing and routing tests of dsir_top
// Assumes: inputs change at the falling edge
// Notes: every wait is bounded
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst, cpu_wr, cpu_rd, fire, cpu_rd_valid, l6, l7, l10, l11, ch4, ch5;
	logic [15:0] cpu_addr, cpu_wdata, cpu_rdata;
	logic [3:0] code, seen;
	logic [8:0] src;
	logic [5:0] half, full, fend, bend, sync, unsync;
	logic [3:0] sc [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'hd, 4'he, 4'hf};
	logic [3:0] si [9] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
	logic [8:0] un = 9'b0_0000_1001;
	logic [15:0] md [6] = '{16'h0000, 16'h3000, 16'h4000, 16'h6000, 16'h5000, 16'h7000};
	int miscompares, check_count, hs, hi, h5;
	dsir_top dsir_top_inst (.ref_clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
		.cpu_rd_valid, .serial0_rx_evt(src[0]), .serial0_tx_evt(src[1]),
		.serial1_rx_evt(src[2]), .serial1_tx_evt(src[3]), .timer0_irq(src[4]),
		.ext_irq3_pin(src[5]), .timer1_irq(src[6]), .serial1_rx_irq(src[7]),
		.serial1_tx_irq(src[8]), .buf_half_evt(half), .buf_full_evt(full),
		.frame_end_evt(fend), .block_end_evt(bend), .chan_sync_evt(sync),
		.chan_unsync(unsync), .cpu_irq_line6(l6), .cpu_irq_line7(l7), .cpu_irq_line10(l10),
		.cpu_irq_line11(l11), .dma_ch4_irq(ch4), .dma_ch5_irq(ch5));
	dsir_src_model dsir_src_model_inst (.ref_clk, .fire, .code, .src);
	// ----
	// tasks
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word
	// idle cycle after each write so the strobe never toggles twice in one step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge ref_clk);
		cpu_wr = 1'b0;
		@(negedge ref_clk);
	endtask : wr
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
		int n;
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge ref_clk);
		cpu_rd = 1'b0;
		for (n = 0; n < 4 && cpu_rd_valid !== 1'b1; n++) begin
			@(negedge ref_clk);
		end
		if (n == 4) begin
			miscompares++;
			end_of_test();
		end
		chk_word(what, exp, cpu_rdata);
		@(negedge ref_clk);
	endtask : rd_chk
	// count pulses over n cycles; stimulus set before the call lasts one cycle
	// cleared at the first edge only, so the next request never meets a second write
	task automatic watch(input int n);
		hs = 0;
		hi = 0;
		h5 = 0;
		seen = 4'h0;
		for (int k = 0; k < n; k++) begin
			@(negedge ref_clk);
			if (k == 0) begin
				fire <= 1'b0;
				{half, full, fend, bend} <= '0;
			end
			hs += int'(sync[0]);
			hi += int'(ch4);
			h5 += int'(ch5);
			seen |= {l11, l10, l7, l6};
		end
	endtask : watch
	// ----
	// sequence
	// ----
	initial begin
		{cpu_wr, cpu_rd, fire, code, cpu_addr, cpu_wdata, half, full, fend, bend} = '0;
		rst = 1'b1;
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		chk_word("unsync", 16'h003f, {10'h000, unsync});
		rd_chk(16'h0054, 16'h0000, "ctrl");
		wr(16'h0055, 16'h0003);
		wr(16'h0056, 16'h1234);
		wr(16'h0056, 16'h5678);
		rd_chk(16'h0055, 16'h0005, "ptr");
		wr(16'h0055, 16'h0003);
		rd_chk(16'h0057, 16'h1234, "plain");
		rd_chk(16'h0055, 16'h0003, "ptr");
		rd_chk(16'h0056, 16'h1234, "autoinc");
		rd_chk(16'h0056, 16'h5678, "autoinc");
		wr(16'h0058, 16'hffff);
		rd_chk(16'h0058, 16'h0000, "unmapped");
		// each defined sync code on channel 0, plus zero and the reserved 0011b
		wr(16'h0055, 16'h0003);
		foreach (sc[i]) begin
			wr(16'h0057, {sc[i], 12'h000});
			chk_word("unsync0", {15'h0, un[i]}, {15'h0, unsync[0]});
			fire <= 1'b1;
			code <= si[i];
			watch(8);
			chk_word("sync0", {15'h0, !un[i]}, 16'(hs));
		end
		// channels 4 and 5 irq per mode; odd events are full and block end
		foreach (md[i]) begin
			wr(16'h0055, 16'h0018);
			wr(16'h0057, md[i]);
			wr(16'h0055, 16'h001d);
			wr(16'h0057, md[i]);
			for (int e = 0; e < 4; e++) begin
				if (md[i][12] == (e < 2)) begin
					{half, full, fend, bend} <= {(e == 0) ? 6'h30 : 6'h00, (e == 1) ? 6'h30 : 6'h00,
						(e == 2) ? 6'h30 : 6'h00, (e == 3) ? 6'h30 : 6'h00};
					watch(3);
					chk_word("ch4 irq", {15'h0, md[i][14] & (e[0] | md[i][13])}, 16'(hi));
					chk_word("ch5 irq", {15'h0, md[i][14] & (e[0] | md[i][13])}, 16'(h5));
				end
			end
		end
		// routing: channels 0..3 irq at block end
		for (int c = 0; c < 4; c++) begin
			wr(16'h0055, 16'(5 * c + 4));
			wr(16'h0057, 16'h4000);
		end
		for (int s = 0; s < 4; s++) begin
			wr(16'h0054, {8'h00, 2'(s), 6'h00});
			bend <= 6'h0f;
			watch(3);
			chk_word("dma lines", {12'h0, s == 2 ? 4'hf : s == 1 ? 4'hc : 4'h0}, {12'h0, seen});
			fire <= 1'b1;
			code <= 4'h6;
			watch(4);
			chk_word("timer1 line", {12'h0, s == 2 ? 4'h0 : 4'h2}, {12'h0, seen});
			fire <= 1'b1;
			code <= 4'h7;
			watch(4);
			chk_word("ser1 line", {12'h0, s % 3 == 0 ? 4'h4 : 4'h0}, {12'h0, seen});
		end
		// mid-run reset: line select back to 00b, pointer back to zero
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		rd_chk(16'h0054, 16'h0000, "ctrl");
		rd_chk(16'h0055, 16'h0000, "ptr");
		fire <= 1'b1;
		code <= 4'h6;
		watch(4);
		chk_word("timer1 line", 16'h0002, {12'h0, seen});
		end_of_test();
	end
endmodule : tb
